// ===== hw/ich_core.sv
// Purpose: executes the general device commands of the controller
// Assumes: commands arrive parsed as opcode plus numeric argument
// Notes:   answers leave as kind plus value; a formatter makes text
`timescale 1ns/1ps
`default_nettype none
// Contract
// - unsupported command logs 533 or 433
// - unsupported query answers -inf and logs
// - out of range keeps value, logs 222/223
// - nonzero argument counts as true
// - beeper argument 0 off, 1 on, 2 beep
// - disabled beeper silences all local sounds
// - beeper query answers 0 off, 1 on
// - beeper enabled by default, off only by 0
// - checksum query sums configuration parameters
// - checksum ignores modules and functionality
// - delay suspends later commands for milliseconds
// - delay holds operation complete false
// - error query lists codes since last query
// - empty error list answers code 0
// - error list answered as character data
// - only remote errors enter the list
module ich_core (
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  input  wire logic                          ce,        // clock enable
  input  wire logic                          cmd_vld,   // command offered
  output logic                               cmd_rdy,   // ready for a command
  input  wire logic [3:0]                    cmd_op,    // opcode
  input  wire logic [ich_pkg::ICH_ARG_W-1:0] cmd_arg,   // argument
  input  wire logic                          cmd_tec,   // target is tec
  input  wire logic [2:0]                    cmd_sel,   // parameter slot
  input  wire logic [ich_pkg::ICH_ARG_W-1:0] cmd_min,   // legal minimum
  input  wire logic [ich_pkg::ICH_ARG_W-1:0] cmd_max,   // legal maximum
  input  wire logic                          remote,    // under remote
  input  wire logic                          loc_err,   // local error
  input  wire logic [ich_pkg::ICH_ERR_W-1:0] loc_code,  // its code
  input  wire logic                          loc_beep,  // panel beep req
  output logic                               rsp_vld,   // answer strobe
  output logic      [1:0]                    rsp_kind,  // answer kind
  output logic      [ich_pkg::ICH_ARG_W-1:0] rsp_val,   // number/code
  output logic                               rsp_last,  // last list item
  output logic                               opc,       // op complete
  output logic                               beep_en,   // sounder enabled
  output logic                               sounder,   // sounder drive
  output logic      [ich_pkg::ICH_ARG_W-1:0] cfg_out    // slot 0 value
);
  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    ICH_ST_IDLE  = 2'b00,  // ready for a command
    ICH_ST_DELAY = 2'b01,  // millisecond pause
    ICH_ST_LIST  = 2'b10   // sending error list
  } ich_st_e;
  localparam logic [ich_pkg::ICH_TICK_W-1:0] TICK_LAST =
    ich_pkg::ICH_TICK_W'(ich_pkg::ICH_MS_CYC - 1);
  localparam logic [ich_pkg::ICH_ARG_W-1:0] BEEP_CYC =
    ich_pkg::ICH_ARG_W'(ich_pkg::ICH_BEEP_MS * ich_pkg::ICH_MS_CYC);
  ich_st_e                       st_ff, nxt_st;        // main state
  logic [ich_pkg::ICH_TICK_W-1:0] tick_ff, nxt_tick;   // ms prescaler
  logic [ich_pkg::ICH_ARG_W-1:0] ms_ff, nxt_ms;        // ms left
  logic                          beep_ff, nxt_beep;    // enable state
  logic [ich_pkg::ICH_ARG_W-1:0] snd_ff, nxt_snd;      // beep cycles
  logic [ich_pkg::ICH_ARG_W-1:0] cfg_ff [ich_pkg::ICH_CH_N]; // params
  logic [ich_pkg::ICH_ARG_W-1:0] nxt_cfg;              // slot write
  logic                          cfg_we;               // slot write en
  logic                          rv_ff, nxt_rv;        // answer strobe
  logic [1:0]                    rk_ff, nxt_rk;        // answer kind
  logic [ich_pkg::ICH_ARG_W-1:0] rval_ff, nxt_rval;    // answer value
  logic                          rl_ff, nxt_rl;        // last item
  logic [ich_pkg::ICH_CNT_W-1:0] li_ff, nxt_li;        // list index
  logic [ich_pkg::ICH_CNT_W-1:0] ln_ff, nxt_ln;        // list length
  logic                          log_vld;              // log strobe
  logic [ich_pkg::ICH_ERR_W-1:0] log_code;             // code to log
  logic                          rd_clr;               // empty list
  logic [ich_pkg::ICH_ERR_W-1:0] rd_code;              // list entry
  logic [ich_pkg::ICH_CNT_W-1:0] err_cnt;              // list count
  logic                          take;                 // command taken
  logic [ich_pkg::ICH_ARG_W-1:0] cksum;                // config sum
  // -------------------------------------------------------------------
  // helpers and error list
  // -------------------------------------------------------------------
  // unsupported error code by target kind
  function automatic logic [ich_pkg::ICH_ERR_W-1:0] ich_uns_code(
    input logic tec);
    ich_uns_code = tec ? ich_pkg::ICH_E_UNS_TEC : ich_pkg::ICH_E_UNS_LAS;
  endfunction
  // nonzero numeric argument reads as true
  function automatic logic ich_bool(
    input logic [ich_pkg::ICH_ARG_W-1:0] a);
    ich_bool = |a;
  endfunction
  // error code store, emptied when the list is read
  ich_err_list u_err (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .ce       (ce),
    .log_vld  (log_vld),
    .log_code (log_code),
    .rd_clr   (rd_clr),
    .rd_idx   (li_ff),
    .rd_code  (rd_code),
    .count    (err_cnt)
  );
  // checksum over configuration slots only, no module presence
  always_comb begin
    cksum = '0;
    for (int i = 0; i < ich_pkg::ICH_CH_N; i++) begin
      cksum = cksum + cfg_ff[i];
    end
  end
  // taken only when idle and no answer strobe is out
  assign take    = ce && cmd_vld && cmd_rdy;
  assign cmd_rdy = (st_ff == ICH_ST_IDLE) && !rv_ff;
  // -------------------------------------------------------------------
  // command execution, next state
  // -------------------------------------------------------------------
  always_comb begin
    nxt_st   = st_ff;
    nxt_tick = tick_ff;
    nxt_ms   = ms_ff;
    nxt_beep = beep_ff;
    nxt_snd  = (snd_ff != '0) ? snd_ff - 32'h0000_0001 : snd_ff;
    nxt_rv   = 1'b0;
    nxt_rk   = rk_ff;
    nxt_rval = rval_ff;
    nxt_rl   = rl_ff;
    nxt_li   = li_ff;
    nxt_ln   = ln_ff;
    nxt_cfg  = cmd_arg;
    cfg_we   = 1'b0;
    log_vld  = 1'b0;
    log_code = ich_pkg::ICH_E_NONE;
    rd_clr   = 1'b0;
    // local errors enter the list only under remote control
    if (loc_err && remote) begin
      log_vld  = 1'b1;
      log_code = loc_code;
    end
    // panel beeps only when enabled
    if (loc_beep && beep_ff) begin
      nxt_snd = BEEP_CYC;
    end
    case (st_ff)
      ICH_ST_IDLE: begin
        if (take) begin
          case (cmd_op)
            ich_pkg::ICH_OP_BEEPER: begin
              // 0 off, 1 on, 2 beep once; else high range error
              if (cmd_arg == ich_pkg::ICH_BEEP_OFF) begin
                nxt_beep = 1'b0;
              end else if (cmd_arg == ich_pkg::ICH_BEEP_ON) begin
                nxt_beep = 1'b1;
              end else if (cmd_arg == ich_pkg::ICH_BEEP_ONCE) begin
                nxt_snd = BEEP_CYC;
              end else begin
                log_vld  = 1'b1;
                log_code = ich_pkg::ICH_E_HIGH;
              end
            end
            ich_pkg::ICH_OP_BEEPER_Q: begin
              nxt_rv   = 1'b1;
              nxt_rk   = ich_pkg::ICH_RSP_NUM;
              nxt_rval = {31'h0000_0000, beep_ff};
              nxt_rl   = 1'b1;
            end
            ich_pkg::ICH_OP_CKSUM_Q: begin
              nxt_rv   = 1'b1;
              nxt_rk   = ich_pkg::ICH_RSP_NUM;
              nxt_rval = cksum;
              nxt_rl   = 1'b1;
            end
            ich_pkg::ICH_OP_DELAY: begin
              if (cmd_arg != '0) begin
                nxt_st   = ICH_ST_DELAY;
                nxt_ms   = cmd_arg;
                nxt_tick = '0;
              end
            end
            ich_pkg::ICH_OP_ERR_Q: begin
              // snapshot length and empty the store; empty list gives 0
              rd_clr   = 1'b1;
              nxt_rv   = 1'b1;
              nxt_rk   = ich_pkg::ICH_RSP_LIST;
              nxt_rval = (err_cnt == '0) ? '0 : 32'(rd_code);
              nxt_rl   = (err_cnt <= 5'h01);
              // index back to slot 0 when the answer is one item
              nxt_li   = (err_cnt > 5'h01) ? 5'h01 : 5'h00;
              nxt_ln   = err_cnt;
              nxt_st   = (err_cnt > 5'h01) ? ICH_ST_LIST : ICH_ST_IDLE;
            end
            ich_pkg::ICH_OP_OPC_Q: begin
              // only reached after any delay has ended
              nxt_rv   = 1'b1;
              nxt_rk   = ich_pkg::ICH_RSP_NUM;
              nxt_rval = 32'h0000_0001;
              nxt_rl   = 1'b1;
            end
            ich_pkg::ICH_OP_SET: begin
              // out of range leaves the slot; boolean slots take any value
              if (cmd_arg > cmd_max &&
                  !(cmd_min == '0 && cmd_max == 32'h0000_0001)) begin
                log_vld  = 1'b1;
                log_code = ich_pkg::ICH_E_HIGH;
              end else if (cmd_arg < cmd_min) begin
                log_vld  = 1'b1;
                log_code = ich_pkg::ICH_E_LOW;
              end else begin
                cfg_we   = 1'b1;
                nxt_cfg  = (cmd_min == '0 && cmd_max == 32'h0000_0001)
                           ? {31'h0000_0000, ich_bool(cmd_arg)} : cmd_arg;
              end
            end
            ich_pkg::ICH_OP_UNSUP: begin
              log_vld  = 1'b1;
              log_code = ich_uns_code(cmd_tec);
            end
            ich_pkg::ICH_OP_UNSUP_Q: begin
              log_vld  = 1'b1;
              log_code = ich_uns_code(cmd_tec);
              nxt_rv   = 1'b1;
              nxt_rk   = ich_pkg::ICH_RSP_NINF;
              nxt_rval = '0;
              nxt_rl   = 1'b1;
            end
            default: nxt_st = ICH_ST_IDLE;
          endcase
        end
      end
      ICH_ST_DELAY: begin
        // count whole milliseconds, then resume
        if (tick_ff == TICK_LAST) begin
          nxt_tick = '0;
          nxt_ms   = ms_ff - 32'h0000_0001;
          if (ms_ff == 32'h0000_0001) begin
            nxt_st = ICH_ST_IDLE;
          end
        end else begin
          nxt_tick = tick_ff + 17'h0_0001;
        end
      end
      ICH_ST_LIST: begin
        // one entry per cycle from the snapshot taken at the query
        nxt_rv   = 1'b1;
        nxt_rk   = ich_pkg::ICH_RSP_LIST;
        nxt_rval = {22'h00_0000, rd_code};
        nxt_li   = li_ff + 5'h01;
        nxt_rl   = (nxt_li == ln_ff);
        if (nxt_li == ln_ff) begin
          nxt_st = ICH_ST_IDLE;
          nxt_li = '0;
        end
      end
      default: nxt_st = ICH_ST_IDLE;
    endcase
  end
  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_ff   <= ICH_ST_IDLE;
      tick_ff <= '0;
      ms_ff   <= '0;
      beep_ff <= ich_pkg::ICH_BEEP_RST;
      snd_ff  <= '0;
      rv_ff   <= 1'b0;
      rk_ff   <= ich_pkg::ICH_RSP_NUM;
      rval_ff <= '0;
      rl_ff   <= 1'b0;
      li_ff   <= '0;
      ln_ff   <= '0;
      for (int i = 0; i < ich_pkg::ICH_CH_N; i++) begin
        cfg_ff[i] <= '0;
      end
    end else if (ce) begin
      st_ff   <= nxt_st;
      tick_ff <= nxt_tick;
      ms_ff   <= nxt_ms;
      beep_ff <= nxt_beep;
      snd_ff  <= nxt_beep ? nxt_snd : '0;
      rv_ff   <= nxt_rv;
      rk_ff   <= nxt_rk;
      rval_ff <= nxt_rval;
      rl_ff   <= nxt_rl;
      li_ff   <= nxt_li;
      ln_ff   <= nxt_ln;
      if (cfg_we) begin
        cfg_ff[cmd_sel] <= nxt_cfg;
      end
    end
  end
  // outputs straight from the registers
  assign rsp_vld  = rv_ff;
  assign rsp_kind = rk_ff;
  assign rsp_val  = rval_ff;
  assign rsp_last = rl_ff;
  assign opc      = (st_ff != ICH_ST_DELAY);
  assign beep_en  = beep_ff;
  assign sounder  = (snd_ff != '0);
  assign cfg_out  = cfg_ff[0];
  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  chk_delay_opc_low: assert property (
    (st_ff == ICH_ST_DELAY) |-> (!opc && !cmd_rdy))
    else $error("opc or ready high during delay");
  chk_beep_default: assert property (
    (take && cmd_op == ich_pkg::ICH_OP_BEEPER && cmd_arg == '0) |=> !beep_en)
    else $error("beeper not disabled by zero");
  chk_beep_stay: assert property (
    (beep_en && !(take && cmd_op == ich_pkg::ICH_OP_BEEPER && cmd_arg == '0))
      |=> beep_en)
    else $error("beeper disabled without zero");
  chk_silent_off: assert property ((!beep_en && ce) |=> !sounder)
    else $error("sound while disabled");
  chk_beep_query: assert property (
    (take && cmd_op == ich_pkg::ICH_OP_BEEPER_Q)
      |=> (rsp_vld && rsp_val == {31'h0, $past(beep_en)}))
    else $error("beeper query answer wrong");
  chk_unsup_ninf: assert property (
    (take && cmd_op == ich_pkg::ICH_OP_UNSUP_Q)
      |-> (log_vld && log_code == ich_uns_code(cmd_tec))
      ##1 (rsp_vld && rsp_kind == ich_pkg::ICH_RSP_NINF))
    else $error("unsupported query not answered");
  chk_unsup_log: assert property (
    (take && cmd_op == ich_pkg::ICH_OP_UNSUP && cmd_tec)
      |-> (log_vld && log_code == ich_pkg::ICH_E_UNS_TEC))
    else $error("unsupported command not logged");
  chk_range_keep: assert property (
    (take && cmd_op == ich_pkg::ICH_OP_SET && cmd_arg > cmd_max
      && !(cmd_min == '0 && cmd_max == 32'h0000_0001))
      |-> (!cfg_we && log_code == ich_pkg::ICH_E_HIGH))
    else $error("over range value accepted");
  chk_err_empty: assert property (
    (take && cmd_op == ich_pkg::ICH_OP_ERR_Q && err_cnt == '0)
      |=> (rsp_vld && rsp_val == '0 && rsp_last))
    else $error("empty list not answered with zero");
  chk_local_skip: assert property (
    (!remote && loc_err && !take) |-> !log_vld)
    else $error("local error logged");
endmodule
`default_nettype wire

// ===== pkg/ich_pkg.sv
// Purpose: shared constants for the instrument command handler
// Assumes: one 125 MHz system clock, commands arrive already parsed
// Notes:   error codes are held as numbers, not text
`default_nettype none
package ich_pkg;
  // -------------------------------------------------------------------
  // command opcodes
  // -------------------------------------------------------------------
  typedef enum logic [3:0] {
    ICH_OP_NONE     = 4'h0,
    ICH_OP_BEEPER   = 4'h1,  // sounder control, argument 0/1/2
    ICH_OP_BEEPER_Q = 4'h2,  // sounder enable query
    ICH_OP_CKSUM_Q  = 4'h3,  // configuration checksum query
    ICH_OP_DELAY    = 4'h4,  // millisecond pause
    ICH_OP_ERR_Q    = 4'h5,  // error list query
    ICH_OP_OPC_Q    = 4'h6,  // operation complete query
    ICH_OP_SET      = 4'h7,  // range checked parameter write
    ICH_OP_UNSUP    = 4'h8,  // command not supported by target module
    ICH_OP_UNSUP_Q  = 4'h9   // query not supported by target module
  } ich_op_e;

  // -------------------------------------------------------------------
  // widths
  // -------------------------------------------------------------------
  localparam int ICH_ARG_W  = 32;  // numeric argument width
  localparam int ICH_ERR_W  = 10;  // error code width
  localparam int ICH_ERR_N  = 16;  // depth of stored error list
  localparam int ICH_CNT_W  = 5;   // error count width
  localparam int ICH_CH_N   = 8;   // configuration parameters summed

  // -------------------------------------------------------------------
  // error codes
  // -------------------------------------------------------------------
  localparam logic [ICH_ERR_W-1:0] ICH_E_NONE    = 10'h000; // code 0
  localparam logic [ICH_ERR_W-1:0] ICH_E_HIGH    = 10'h0de; // 222
  localparam logic [ICH_ERR_W-1:0] ICH_E_LOW     = 10'h0df; // 223
  localparam logic [ICH_ERR_W-1:0] ICH_E_UNS_TEC = 10'h1b1; // 433
  localparam logic [ICH_ERR_W-1:0] ICH_E_UNS_LAS = 10'h215; // 533

  // -------------------------------------------------------------------
  // beeper arguments and query answers
  // -------------------------------------------------------------------
  localparam logic [ICH_ARG_W-1:0] ICH_BEEP_OFF  = 32'h0000_0000;
  localparam logic [ICH_ARG_W-1:0] ICH_BEEP_ON   = 32'h0000_0001;
  localparam logic [ICH_ARG_W-1:0] ICH_BEEP_ONCE = 32'h0000_0002;
  localparam logic               ICH_BEEP_RST  = 1'b1; // enabled

  // -------------------------------------------------------------------
  // answer kinds
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    ICH_RSP_NUM  = 2'b00,  // one integer, as text
    ICH_RSP_NINF = 2'b01,  // the text -inf
    ICH_RSP_LIST = 2'b10   // comma separated error list, as text
  } ich_rsp_e;

  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int ICH_CLK_MHZ  = 125;
  localparam int ICH_MS_NS    = 1000000;                 // one ms in ns
  localparam int ICH_CLK_NS   = 1000 / ICH_CLK_MHZ;      // 8 ns
  localparam int ICH_MS_CYC   = ICH_MS_NS / ICH_CLK_NS;  // 125000
  localparam int ICH_BEEP_MS  = 100;                     // one beep
  localparam int ICH_TICK_W   = 17;                      // holds MS_CYC
endpackage
`default_nettype wire

// ===== hw/ich_err_list.sv
// Purpose: stores logged error codes until the list is read
// Assumes: one log per cycle at most
// Notes:   read empties the list; a log in the read cycle is kept
`timescale 1ns/1ps
`default_nettype none
module ich_err_list (
  input  wire logic                            clk_sys,
  input  wire logic                            rst,
  input  wire logic                            ce,
  input  wire logic                            log_vld,  // log strobe
  input  wire logic [ich_pkg::ICH_ERR_W-1:0]   log_code, // code to log
  input  wire logic                            rd_clr,   // list read
  input  wire logic [ich_pkg::ICH_CNT_W-1:0]   rd_idx,   // entry index
  output logic      [ich_pkg::ICH_ERR_W-1:0]   rd_code,  // entry code
  output logic      [ich_pkg::ICH_CNT_W-1:0]   count     // stored count
);
  // -------------------------------------------------------------------
  // storage
  // -------------------------------------------------------------------
  logic [ich_pkg::ICH_ERR_W-1:0] mem_ff [ich_pkg::ICH_ERR_N]; // codes
  logic [ich_pkg::ICH_CNT_W-1:0] cnt_ff;      // entries held
  logic [ich_pkg::ICH_CNT_W-1:0] nxt_cnt;     // next count
  logic [ich_pkg::ICH_CNT_W-1:0] wr_idx;      // write slot
  logic                          wr_en;       // write this cycle

  // next count; read empties, a same cycle log survives in slot 0
  always_comb begin
    wr_en   = 1'b0;
    wr_idx  = cnt_ff;
    nxt_cnt = cnt_ff;
    if (rd_clr) begin
      nxt_cnt = '0;
      wr_idx  = '0;
    end
    if (log_vld && (rd_clr || (32'(cnt_ff) < ich_pkg::ICH_ERR_N))) begin
      wr_en   = 1'b1;
      nxt_cnt = ICH_CNT_INC(rd_clr ? '0 : cnt_ff);
    end
  end

  // count register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
    end
  end

  // code memory, no reset needed
  always_ff @(posedge clk_sys) begin
    if (ce && wr_en) begin
      mem_ff[wr_idx[3:0]] <= log_code;
    end
  end

  // increment helper
  function automatic logic [ich_pkg::ICH_CNT_W-1:0] ICH_CNT_INC(
    input logic [ich_pkg::ICH_CNT_W-1:0] v);
    ICH_CNT_INC = v + 5'h01;
  endfunction

  assign rd_code = mem_ff[rd_idx[3:0]];
  assign count   = cnt_ff;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  chk_err_clear: assert property (
    @(posedge clk_sys) disable iff (rst)
    (ce && rd_clr && !log_vld) |=> (count == '0))
    else $error("error list not emptied");
endmodule
`default_nettype wire

// ===== test/ich_host.sv
// Purpose: host side model that offers parsed commands to the core
// Assumes: driven at the falling edge, taken on a rising edge
// Notes:   released op, arg and sel lines show inverted data; tec, min and max keep their last value
`timescale 1ns/1ps
`default_nettype none
module ich_host (
  input  wire logic        clk_sys,
  input  wire logic        cmd_rdy,
  output var  logic        cmd_vld,
  output var  logic [3:0]  cmd_op,
  output var  logic [31:0] cmd_arg,
  output var  logic        cmd_tec,
  output var  logic [2:0]  cmd_sel,
  output var  logic [31:0] cmd_min,
  output var  logic [31:0] cmd_max
);
  initial cmd_vld = 1'b0;
  initial {cmd_op, cmd_arg, cmd_tec, cmd_sel, cmd_min, cmd_max} = '0;
  // offer one command, hold it through the first rising edge with ready high, then release it
  task automatic send(input logic [3:0] op, input logic [31:0] a,
    input logic [2:0] sl = 3'h0, input logic tc = 1'b0,
    input logic [31:0] mn = 32'h0, input logic [31:0] mx = 32'hffff);
    @(negedge clk_sys);
    cmd_vld = 1'b1;
    {cmd_op, cmd_arg, cmd_sel, cmd_tec} = {op, a, sl, tc};
    {cmd_min, cmd_max} = {mn, mx};
    while (cmd_rdy !== 1'b1) @(negedge clk_sys);
    @(posedge clk_sys);
    @(negedge clk_sys);
    cmd_vld = 1'b0;
    {cmd_op, cmd_arg, cmd_sel} = ~{cmd_op, cmd_arg, cmd_sel};
  endtask
endmodule
`default_nettype wire

// ===== test/ich_core_test.sv
// Purpose: self-checking bench for the command core
// Assumes: answers are sampled at the falling edge
// Notes:   random set values come from a fixed-seed shift register
`timescale 1ns/1ps
`default_nettype none
module ich_core_test;
  logic clk_sys = 0, rst = 1, remote = 1, loc_err = 0, loc_beep = 0, ce = 1;
  logic [9:0] loc_code = 10'h000;
  wire logic cmd_vld, cmd_rdy, cmd_tec, rsp_vld, rsp_last, opc, beep_en;
  wire logic sounder;
  wire logic [3:0] cmd_op;
  wire logic [2:0] cmd_sel;
  wire logic [1:0] rsp_kind;
  wire logic [31:0] cmd_arg, cmd_min, cmd_max, rsp_val, cfg_out;
  int error_cnt = 0, n_tests = 0, i;
  logic [31:0] q[$], s, sum, lf = 32'h1e1e;
  ich_host h (.clk_sys(clk_sys), .cmd_rdy(cmd_rdy), .cmd_vld(cmd_vld),
    .cmd_op(cmd_op), .cmd_arg(cmd_arg), .cmd_tec(cmd_tec),
    .cmd_sel(cmd_sel), .cmd_min(cmd_min), .cmd_max(cmd_max));
  ich_core dut (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .cmd_vld(cmd_vld), .cmd_rdy(cmd_rdy), .cmd_op(cmd_op),
    .cmd_arg(cmd_arg), .cmd_tec(cmd_tec), .cmd_sel(cmd_sel),
    .cmd_min(cmd_min), .cmd_max(cmd_max), .remote(remote),
    .loc_err(loc_err), .loc_code(loc_code), .loc_beep(loc_beep),
    .rsp_vld(rsp_vld), .rsp_kind(rsp_kind), .rsp_val(rsp_val),
    .rsp_last(rsp_last), .opc(opc), .beep_en(beep_en),
    .sounder(sounder), .cfg_out(cfg_out));
  initial forever #4 clk_sys = ~clk_sys;
  // collect answer items
  always @(negedge clk_sys) if (rsp_vld === 1'b1) q.push_back(rsp_val);
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic ask(input logic [3:0] op);
    q.delete();
    h.send(op, 32'h0);
    repeat (20) @(negedge clk_sys);
    $display("test op %0d done at %0t", op, $time);
  endtask
  task automatic pulse_err(input logic r, input logic [9:0] c);
    @(negedge clk_sys);
    {remote, loc_err, loc_code} = {r, 1'b1, c};
    @(negedge clk_sys);
    loc_err = 1'b0;
  endtask
  task automatic end_sim();
    $display("tests %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #1_200_000;
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (8) @(negedge clk_sys);
    rst = 0;
    chk(beep_en, 1);
    ask(4'h5);
    chk({32'(q.size()), q[0]}, {32'd1, 32'd0});
    h.send(4'h8, 0, 0, 0);
    h.send(4'h8, 0, 0, 1);
    ask(4'h9);
    chk(rsp_kind, 1);
    ask(4'h5);
    chk({q[0], q[1], q[2]}, {32'd533, 32'd433, 32'd533});
    chk(rsp_last, 1);
    ask(4'h5);
    chk(32'(q.size()) + q[0], 1);
    sum = 0;
    for (i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      s = {16'h0, lf[15:0]};
      h.send(4'h7, s, 3'(i));
      sum += s;
    end
    h.send(4'h7, 32'h20, 0, 0, 32'h10, 32'h1f);
    h.send(4'h7, 32'h05, 0, 0, 32'h10, 32'h1f);
    ask(4'h3);
    chk(q[0], sum);
    h.send(4'h8, 0, 0, 1);
    ask(4'h3);
    chk(q[0], sum);
    ask(4'h5);
    chk({q[0], q[1]}, {32'd222, 32'd223});
    chk(rsp_kind, 2);
    h.send(4'h7, 32'h7, 0, 0, 0, 1);
    repeat (2) @(negedge clk_sys);
    chk(cfg_out, 1);
    ce = 0;
    h.send(4'h1, 0);
    chk(beep_en, 1);
    ce = 1;
    h.send(4'h1, 0);
    ask(4'h2);
    chk({q[0], 31'h0, beep_en}, 0);
    @(negedge clk_sys) loc_beep = 1;
    @(negedge clk_sys) loc_beep = 0;
    chk(sounder, 0);
    h.send(4'h1, 1);
    ask(4'h2);
    chk(q[0], 1);
    h.send(4'h1, 2);
    repeat (2) @(negedge clk_sys);
    chk(sounder, 1);
    pulse_err(0, 10'h12c);
    pulse_err(1, 10'h0c9);
    ask(4'h5);
    chk({q[0], 31'h0, rsp_last}, {32'd201, 32'h1});
    h.send(4'h4, 1);
    chk({opc, cmd_rdy}, 0);
    for (i = 1; opc !== 1'b1 && i < 200000; i++) @(negedge clk_sys);
    chk(i > 124998 && i < 125003, 1);
    ask(4'h6);
    chk(q[0], 1);
    end_sim();
  end
endmodule
`default_nettype wire
